//--- apt_pkg.sv
package apt_pkg;
    // Memory clock period in picoseconds (20 MHz)
    localparam int APT_CLK_PS = 50000;
    localparam int APT_BANKS = 8;
    localparam int APT_BANK_W = 3;
    localparam int APT_CNT_W = 8;
    localparam int APT_LOAD_BIAS = 2;
    localparam int APT_WR_TAIL = 1;
    localparam int APT_RTP_BASE = 2;
    localparam logic [APT_CNT_W-1:0] APT_CNT_ZERO = 8'h00;
    localparam logic [APT_CNT_W-1:0] APT_CNT_ONE = 8'h01;

    typedef enum logic [2:0] {
        APT_NOP,
        APT_ACT,
        APT_RD,
        APT_WR,
        APT_BST,
        APT_PRE,
        APT_PRE_ALL
    } apt_cmd_e;

    typedef enum logic [1:0] {
        APT_BK_IDLE,
        APT_BK_OPEN,
        APT_BK_AP_WAIT,
        APT_BK_PRECH
    } apt_bank_st_e;

    // Round a time in ps up to whole clock cycles, never below one
    function automatic int apt_ru(input int t_ps);
        int c;
        c = (t_ps + APT_CLK_PS - 1) / APT_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : apt_ru

    function automatic int apt_max(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : apt_max
endpackage : apt_pkg

//--- apt_bank_if.sv
`timescale 1ns/10ps
interface apt_bank_if;
    logic ce;
    logic act;
    logic rd_ap;
    logic wr_ap;
    logic pre;
    logic ap_busy;
    logic pre_start;
    logic idle;

    modport ctrl (output ce, output act, output rd_ap, output wr_ap, output pre,
                  input ap_busy, input pre_start, input idle);
    modport bank (input ce, input act, input rd_ap, input wr_ap, input pre,
                  output ap_busy, output pre_start, output idle);
endinterface : apt_bank_if

//--- apt_bank_timer.sv
`timescale 1ns/10ps
module apt_bank_timer
    import apt_pkg::*;
#(
    parameter int RD_DLY = 4,
    parameter int WR_DLY = 6,
    parameter int RP_CYC = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    apt_bank_if.bank bk
);
    localparam logic [APT_CNT_W-1:0] RD_LOAD = APT_CNT_W'(RD_DLY - APT_LOAD_BIAS);
    localparam logic [APT_CNT_W-1:0] WR_LOAD = APT_CNT_W'(WR_DLY - APT_LOAD_BIAS);
    localparam logic [APT_CNT_W-1:0] RP_LOAD = APT_CNT_W'(RP_CYC - 1);

    typedef struct packed {
        apt_bank_st_e st;
        logic [APT_CNT_W-1:0] cnt;
        logic pre_start;
        logic was_wr;
    } apt_bank_s;

    apt_bank_s cur_r;
    apt_bank_s cur_nxt;

    // Per-bank sequencer: open, auto-close wait, precharge period
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.pre_start = 1'b0;
        unique case (cur_r.st)
            APT_BK_IDLE, APT_BK_OPEN: begin
                if (bk.rd_ap) begin
                    cur_nxt.st = APT_BK_AP_WAIT;
                    cur_nxt.cnt = RD_LOAD;
                    cur_nxt.was_wr = 1'b0;
                end else if (bk.wr_ap) begin
                    cur_nxt.st = APT_BK_AP_WAIT;
                    cur_nxt.cnt = WR_LOAD;
                    cur_nxt.was_wr = 1'b1;
                end else if (bk.pre) begin
                    cur_nxt.st = APT_BK_PRECH;
                    cur_nxt.cnt = RP_LOAD;
                end else if (bk.act) begin
                    cur_nxt.st = APT_BK_OPEN;
                end
            end
            APT_BK_AP_WAIT: begin
                // Reads and writes to this bank are ignored until it closes
                if (cur_r.cnt == APT_CNT_ZERO) begin
                    cur_nxt.pre_start = 1'b1;
                    cur_nxt.st = APT_BK_PRECH;
                    cur_nxt.cnt = RP_LOAD;
                end else begin
                    cur_nxt.cnt = cur_r.cnt - APT_CNT_ONE;
                end
            end
            APT_BK_PRECH: begin
                // A new precharge restarts the period from the latest one
                if (bk.pre) begin
                    cur_nxt.cnt = RP_LOAD;
                end else if (bk.act) begin
                    cur_nxt.st = APT_BK_OPEN;
                end else if (cur_r.cnt == APT_CNT_ZERO) begin
                    cur_nxt.st = APT_BK_IDLE;
                end else begin
                    cur_nxt.cnt = cur_r.cnt - APT_CNT_ONE;
                end
            end
        endcase
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur_r <= '{st: APT_BK_IDLE, cnt: APT_CNT_ZERO, pre_start: 1'b0, was_wr: 1'b0};
        end else if (bk.ce) begin
            cur_r <= cur_nxt;
        end
    end

    assign bk.ap_busy = (cur_r.st == APT_BK_AP_WAIT);
    assign bk.pre_start = cur_r.pre_start;
    assign bk.idle = (cur_r.st == APT_BK_IDLE);

    // Helper: enabled edges since the auto-close command was taken
    logic [APT_CNT_W-1:0] age_r;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            age_r <= APT_CNT_ZERO;
        end else if (bk.ce) begin
            age_r <= (cur_nxt.st == APT_BK_AP_WAIT && cur_r.st != APT_BK_AP_WAIT) ?
                     APT_CNT_ZERO : age_r + APT_CNT_ONE;
        end
    end

    rd_ap_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(cur_r.pre_start) && !cur_r.was_wr |-> age_r == APT_CNT_W'(RD_DLY - 1))
        else $error("read auto-close started at wrong cycle");
    wr_ap_delay_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(cur_r.pre_start) && cur_r.was_wr |-> age_r == APT_CNT_W'(WR_DLY - 1))
        else $error("write auto-close started at wrong cycle");
    busy_ends_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(bk.ap_busy) |-> cur_r.pre_start && cur_r.st == APT_BK_PRECH)
        else $error("auto-close wait ended without precharge start");
    ap_engage_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bk.ce && (bk.rd_ap || bk.wr_ap) && !bk.ap_busy && cur_r.st != APT_BK_PRECH
        |=> bk.ap_busy && cur_r.was_wr == $past(bk.wr_ap))
        else $error("auto-close command not engaged");

    rd_close_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        cur_r.pre_start && !cur_r.was_wr);
    wr_close_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        cur_r.pre_start && cur_r.was_wr);
endmodule : apt_bank_timer

//--- apt_auto_close.sv
`timescale 1ns/10ps
// Contract
// - Read with auto_close_flag set engages automatic bank close after the burst.
// - Read auto-close precharge starts max(BL/2, BL/2-2+RU(read_to_precharge_time)) cycles after command.
// - Write with auto_close_flag starts precharge write recovery cycles after burst end.
// - Gapless auto-close reads, or writes, to different banks are supported.
module apt_auto_close
    import apt_pkg::*;
#(
    parameter int BURST_LENGTH = 8,
    parameter int WRITE_LATENCY = 1,
    parameter int READ_TO_PRECHARGE_PS = 7500,
    parameter int WRITE_RECOVERY_PS = 15000,
    parameter int SINGLE_BANK_PRECHARGE_PS = 18000
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire apt_cmd_e cmd_code,
    input wire logic [APT_BANK_W-1:0] cmd_bank,
    input wire logic auto_close_flag,
    output logic [APT_BANKS-1:0] prech_start_r,
    output logic [APT_BANKS-1:0] ap_busy_r,
    output logic [APT_BANKS-1:0] bank_idle_r,
    output logic cmd_illegal_r
);
    // Cycle counts derived from the times and the clock period
    localparam int HALF_BL = BURST_LENGTH / 2;
    localparam int RTP_CYC = apt_ru(READ_TO_PRECHARGE_PS);
    localparam int WR_CYC = apt_ru(WRITE_RECOVERY_PS);
    localparam int RP_CYC = apt_ru(SINGLE_BANK_PRECHARGE_PS);
    localparam int RD_DLY = apt_max(HALF_BL, HALF_BL - APT_RTP_BASE + RTP_CYC);
    localparam int WR_DLY = WRITE_LATENCY + HALF_BL + APT_WR_TAIL + WR_CYC;

    typedef struct packed {
        logic [APT_BANKS-1:0] prech_start;
        logic [APT_BANKS-1:0] ap_busy;
        logic [APT_BANKS-1:0] bank_idle;
        logic illegal;
        logic last_ap;
    } apt_top_s;

    apt_top_s top_r;
    apt_top_s top_nxt;

    logic [APT_BANKS-1:0] busy_w;
    logic [APT_BANKS-1:0] start_w;
    logic [APT_BANKS-1:0] idle_w;

    // True when this command is of the given kind and targets bank idx
    function automatic logic bank_hit(input apt_cmd_e code, input apt_cmd_e want,
                                      input logic [APT_BANK_W-1:0] bank, input int idx);
        return (code == want) && (bank == APT_BANK_W'(idx));
    endfunction : bank_hit

    // One sequencer per bank; different banks run independently, so
    // back-to-back auto-close commands to other banks never collide
    for (genvar i = 0; i < APT_BANKS; i++) begin : g_bank
        apt_bank_if bk_if ();

        assign bk_if.ce = clk_en;
        assign bk_if.act = cmd_valid && bank_hit(cmd_code, APT_ACT, cmd_bank, i);
        assign bk_if.rd_ap = cmd_valid && auto_close_flag &&
                             bank_hit(cmd_code, APT_RD, cmd_bank, i);
        assign bk_if.wr_ap = cmd_valid && auto_close_flag &&
                             bank_hit(cmd_code, APT_WR, cmd_bank, i);
        assign bk_if.pre = cmd_valid && (cmd_code == APT_PRE_ALL ||
                           bank_hit(cmd_code, APT_PRE, cmd_bank, i));
        assign busy_w[i] = bk_if.ap_busy;
        assign start_w[i] = bk_if.pre_start;
        assign idle_w[i] = bk_if.idle;

        apt_bank_timer #(
            .RD_DLY(RD_DLY),
            .WR_DLY(WR_DLY),
            .RP_CYC(RP_CYC)
        ) u_timer (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .bk(bk_if.bank)
        );
    end

    // Status copies and misuse flag; a flag only, the bank is protected anyway
    always_comb begin
        top_nxt = top_r;
        top_nxt.prech_start = start_w;
        top_nxt.ap_busy = busy_w;
        top_nxt.bank_idle = idle_w;
        top_nxt.illegal = 1'b0;
        if (cmd_valid) begin
            if ((cmd_code == APT_RD || cmd_code == APT_WR) && busy_w[cmd_bank]) begin
                top_nxt.illegal = 1'b1;
            end
            if (cmd_code == APT_BST && top_r.last_ap) begin
                top_nxt.illegal = 1'b1;
            end
            if (cmd_code == APT_RD || cmd_code == APT_WR) begin
                top_nxt.last_ap = auto_close_flag;
            end
        end
    end

    // Output registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            top_r <= '0;
        end else if (clk_en) begin
            top_r <= top_nxt;
        end
    end

    assign prech_start_r = top_r.prech_start;
    assign ap_busy_r = top_r.ap_busy;
    assign bank_idle_r = top_r.bank_idle;
    assign cmd_illegal_r = top_r.illegal;

    gapless_rd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && cmd_valid && auto_close_flag && cmd_code == APT_RD && !busy_w[cmd_bank]
        && $past(clk_en && cmd_valid && auto_close_flag && cmd_code == APT_RD, HALF_BL)
        && cmd_bank != $past(cmd_bank, HALF_BL)
        |=> busy_w[$past(cmd_bank)])
        else $error("second of two gapless auto-close reads lost");
    start_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && $rose(prech_start_r[0]) |=> !prech_start_r[0] || !clk_en)
        else $error("precharge start longer than one cycle");
    illegal_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && cmd_valid && cmd_code == APT_RD && busy_w[cmd_bank] |=> cmd_illegal_r)
        else $error("read to closing bank not flagged");

    gapless_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        ap_busy_r[0] && ap_busy_r[1]);
    illegal_c: cover property (@(posedge ref_clk) disable iff (!reset_n) cmd_illegal_r);
    idle_again_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(bank_idle_r[0]));
endmodule : apt_auto_close

//--- apt_ctrl_model.sv
`timescale 1ns/10ps
// Controller stand-in: holds a bank's commands back until its guard runs out
module apt_ctrl_model
    import apt_pkg::*;
#(
    parameter int RD_DLY = 4,
    parameter int WR_DLY = 7,
    parameter int RP_CYC = 1,
    parameter int RD_WR_GAP = 8,
    parameter int WR_RD_GAP = 7,
    parameter int BST_WR_GAP = 4
) (
    input wire logic ref_clk,
    output logic clk_en,
    output logic cmd_valid,
    output apt_cmd_e cmd_code,
    output logic [APT_BANK_W-1:0] cmd_bank,
    output logic auto_close_flag
);
    int guard[APT_BANKS] = '{default: 0};
    // Cross-bank and burst-stop spacings, shared by all banks
    int wr_wait = 0;
    int rd_wait = 0;
    int pre_wait = 0;
    logic last_wr = 1'b0;
    logic go;
    assign go = clk_en & cmd_valid;
    initial begin
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = APT_NOP;
        cmd_bank = 3'h0;
        auto_close_flag = 1'b0;
    end
    // Per-bank countdowns, loaded by every closing command
    always @(posedge ref_clk) begin
        for (int b = 0; b < APT_BANKS; b++) begin
            if (clk_en && guard[b] > 0) guard[b] <= guard[b] - 1;
            if (go && cmd_code == APT_PRE_ALL) guard[b] <= RP_CYC + 1;
        end
        if (go && cmd_code == APT_PRE) guard[cmd_bank] <= RP_CYC + 1;
        if (clk_en && wr_wait > 0) wr_wait <= wr_wait - 1;
        if (clk_en && rd_wait > 0) rd_wait <= rd_wait - 1;
        if (clk_en && pre_wait > 0) pre_wait <= pre_wait - 1;
        if (go && auto_close_flag && cmd_code == APT_RD) wr_wait <= RD_WR_GAP;
        if (go && auto_close_flag && cmd_code == APT_WR) rd_wait <= WR_RD_GAP;
        if (go && (cmd_code == APT_RD || cmd_code == APT_WR)) last_wr <= (cmd_code == APT_WR);
        if (go && cmd_code == APT_BST) pre_wait <= last_wr ? BST_WR_GAP : 1;
        if (go && auto_close_flag && cmd_code == APT_RD) begin
            guard[cmd_bank] <= RD_DLY + RP_CYC + 1;
        end
        if (go && auto_close_flag && cmd_code == APT_WR) begin
            guard[cmd_bank] <= WR_DLY + RP_CYC + 1;
        end
    end
    // Called at a falling edge; waits out the guards, then returns one falling edge after driving, command taken
    task automatic issue(input apt_cmd_e c, input int b, input logic f, input logic frc);
        int n;
        n = 0;
        while (!frc && n < 100 && (guard[b] != 0 || (c == APT_WR && wr_wait != 0) ||
               (c == APT_RD && rd_wait != 0) ||
               ((c == APT_PRE || c == APT_PRE_ALL) && pre_wait != 0))) begin
            @(negedge ref_clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_bank = b[APT_BANK_W-1:0];
        auto_close_flag = f;
        @(negedge ref_clk);
    endtask : issue
    // Released lines show garbage, not the last value
    task automatic stop();
        cmd_valid = 1'b0;
        cmd_code = APT_NOP;
        cmd_bank = ~cmd_bank;
        auto_close_flag = ~auto_close_flag;
    endtask : stop
    task automatic hold(input int n);
        clk_en = 1'b0;
        repeat (n) @(negedge ref_clk);
        clk_en = 1'b1;
    endtask : hold
endmodule : apt_ctrl_model

//--- apt_auto_close_test.sv
`timescale 1ns/10ps
module apt_auto_close_test
    import apt_pkg::*;
;
    localparam int BL = 8;
    localparam int WL = 1;
    localparam int RTP_PS = 200000;
    localparam int WR_PS = 100000;
    localparam int RPB_PS = 120000;
    // Rounded up to whole cycles; read-to-precharge chosen so the second term wins
    localparam int RTP_C = (RTP_PS + APT_CLK_PS - 1) / APT_CLK_PS;
    localparam int RD_DLY = (BL / 2 > BL / 2 - 2 + RTP_C) ? BL / 2 : BL / 2 - 2 + RTP_C;
    localparam int WR_DLY = WL + BL / 2 + 1 + (WR_PS + APT_CLK_PS - 1) / APT_CLK_PS;
    localparam int RP_CYC = (RPB_PS + APT_CLK_PS - 1) / APT_CLK_PS;
    localparam int RL = 3;
    localparam int DQSCK_PS = 5500;
    localparam int WTR_PS = 10000;
    localparam int RD_WR_GAP = RL + BL / 2 + (DQSCK_PS + APT_CLK_PS - 1) / APT_CLK_PS - WL + 1;
    localparam int WR_RD_GAP = WL + BL / 2 + (WTR_PS + APT_CLK_PS - 1) / APT_CLK_PS + 1;
    localparam int BST_WR_GAP = WL + (WR_PS + APT_CLK_PS - 1) / APT_CLK_PS + 1;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en;
    logic cmd_valid;
    logic auto_close_flag;
    apt_cmd_e cmd_code;
    logic [APT_BANK_W-1:0] cmd_bank;
    logic [APT_BANKS-1:0] prech_start_r;
    logic [APT_BANKS-1:0] ap_busy_r;
    logic [APT_BANKS-1:0] bank_idle_r;
    logic cmd_illegal_r;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int ill_seen = 0;

    always #25 ref_clk = ~ref_clk;

    apt_auto_close #(.BURST_LENGTH(BL), .WRITE_LATENCY(WL), .READ_TO_PRECHARGE_PS(RTP_PS),
        .WRITE_RECOVERY_PS(WR_PS), .SINGLE_BANK_PRECHARGE_PS(RPB_PS)) i_apt_auto_close (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_bank(cmd_bank), .auto_close_flag(auto_close_flag),
        .prech_start_r(prech_start_r), .ap_busy_r(ap_busy_r), .bank_idle_r(bank_idle_r),
        .cmd_illegal_r(cmd_illegal_r));
    apt_ctrl_model #(.RD_DLY(RD_DLY), .WR_DLY(WR_DLY), .RP_CYC(RP_CYC),
        .RD_WR_GAP(RD_WR_GAP), .WR_RD_GAP(WR_RD_GAP), .BST_WR_GAP(BST_WR_GAP)) i_apt_ctrl_model (
        .ref_clk(ref_clk), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bank(cmd_bank), .auto_close_flag(auto_close_flag));

    // Flag pulses last one cycle, so count them at every falling edge
    always @(negedge ref_clk) begin
        if (cmd_illegal_r === 1'b1) ill_seen++;
    end
    // Hang guard, well above the roughly 140 cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            $display("[ERR] %0t run timed out", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cmd(input apt_cmd_e c, input int b, input logic f, input logic frc);
        i_apt_ctrl_model.issue(c, b, f, frc);
    endtask : cmd
    // Walks one bank from k edges after the command until it is idle again
    task automatic chk_ap(input int b, input int dly);
        for (int k = 0; k <= dly + RP_CYC + 3; k++) begin
            chk({7'h0, prech_start_r[b]}, {7'h0, k == dly}, "start pulse");
            if (k == 1) chk({7'h0, ap_busy_r[b]}, 8'h01, "wait on");
            if (k == dly + 1) chk({7'h0, ap_busy_r[b]}, 8'h00, "wait off");
            if (k == dly) chk({7'h0, bank_idle_r[b]}, 8'h00, "still open");
            @(negedge ref_clk);
        end
        chk({7'h0, bank_idle_r[b]}, 8'h01, "closed");
    endtask : chk_ap

    task automatic t_reset();
        chk(bank_idle_r, 8'hFF, "idle");
        chk(ap_busy_r | prech_start_r, 8'h00, "quiet");
        $display("reset test done");
    endtask : t_reset
    task automatic t_rd_ap();
        cmd(APT_ACT, 2, 1'b0, 1'b0);
        cmd(APT_RD, 2, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        chk_ap(2, RD_DLY);
        $display("read close test done");
    endtask : t_rd_ap
    task automatic t_wr_ap();
        cmd(APT_ACT, 5, 1'b0, 1'b0);
        cmd(APT_WR, 5, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        chk_ap(5, WR_DLY);
        $display("write close test done");
    endtask : t_wr_ap
    // Two banks closed by seamless commands half a burst apart, reads then writes
    task automatic t_gapless();
        for (int b = 0; b < 5; b++) cmd(APT_ACT, b, 1'b0, 1'b0);
        cmd(APT_RD, 0, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        repeat (BL / 2 - 1) @(negedge ref_clk);
        cmd(APT_RD, 1, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        fork
            chk_ap(0, RD_DLY - BL / 2);
            chk_ap(1, RD_DLY);
        join
        cmd(APT_WR, 3, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        repeat (BL / 2 - 1) @(negedge ref_clk);
        cmd(APT_WR, 4, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        fork
            chk_ap(3, WR_DLY - BL / 2);
            chk_ap(4, WR_DLY);
        join
        $display("gapless test done");
    endtask : t_gapless
    // Stop and re-read forced into a closing bank: flagged, timing untouched
    task automatic t_refuse();
        int base;
        base = ill_seen;
        cmd(APT_ACT, 7, 1'b0, 1'b0);
        cmd(APT_RD, 7, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        @(negedge ref_clk);
        cmd(APT_BST, 7, 1'b0, 1'b1);
        cmd(APT_RD, 7, 1'b0, 1'b1);
        i_apt_ctrl_model.stop();
        chk_ap(7, RD_DLY - 3);
        chk(8'(ill_seen - base), 8'h02, "flags");
        $display("refusal test done");
    endtask : t_refuse
    task automatic t_pre();
        cmd(APT_ACT, 2, 1'b0, 1'b0);
        cmd(APT_PRE, 2, 1'b0, 1'b0);
        cmd(APT_PRE_ALL, 0, 1'b0, 1'b0);
        i_apt_ctrl_model.stop();
        repeat (2) @(negedge ref_clk);
        chk({7'h0, bank_idle_r[2]}, 8'h00, "precharging");
        repeat (RP_CYC + 2) @(negedge ref_clk);
        chk(bank_idle_r, 8'hFF, "all idle");
        $display("precharge test done");
    endtask : t_pre
    // A frozen clock enable delays the close by exactly the frozen cycles
    task automatic t_freeze();
        cmd(APT_ACT, 6, 1'b0, 1'b0);
        cmd(APT_RD, 6, 1'b1, 1'b0);
        i_apt_ctrl_model.stop();
        i_apt_ctrl_model.hold(3);
        chk_ap(6, RD_DLY);
        $display("freeze test done");
    endtask : t_freeze

    initial begin
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_rd_ap();
        t_wr_ap();
        t_gapless();
        t_refuse();
        t_pre();
        t_freeze();
        end_of_test();
    end
endmodule : apt_auto_close_test
